// ==== verilog/ccr_map.svh ====
// Constants for the continuous conversion readback port.
// Assumes inclusion by both ends and the package; definitions only.
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH
`define CCR_FRAME_BITS 32
`define CCR_RESULT_BITS 24
`define CCR_TRAIL_BITS 8
`define CCR_CNT_W 6
`define CCR_FRAME_LAST 6'h1F
`define CCR_FRAME_LEN 6'h20
`define CCR_SCLK_DIV_W 4
`define CCR_SCLK_HALF 4'h3
`define CCR_BUF_DEPTH 2
`define CCR_STATUS_LAST_BIT 0
`endif

// ==== verilog/ccr_pkg.sv ====
// Types shared by both ends of the readback link.
// Assumes ccr_map.svh is on the include path.
`default_nettype none
`include "ccr_map.svh"
package ccr_pkg;
  typedef logic [`CCR_FRAME_BITS-1:0] ccr_frame_t;
  typedef logic [`CCR_RESULT_BITS-1:0] ccr_result_t;
  typedef logic [`CCR_TRAIL_BITS-1:0] ccr_trail_t;
  typedef logic [`CCR_CNT_W-1:0] ccr_cnt_t;
  typedef enum logic [2:0] {
    CCR_IDLE = 3'h1,
    CCR_WAIT = 3'h2,
    CCR_SHIFT = 3'h4
  } ccr_state_t;
endpackage
`default_nettype wire

// ==== verilog/ccr_link_if.sv ====
// Serial link between the converter end and the host end.
// Assumes both ends sit on their own core_clk; pins are plain wires.
`default_nettype none
interface ccr_link_if;
  logic cs_n;
  logic sclk;
  logic sdo;
  logic conversion_ready_strobe;
  logic sync_n;
  modport device (
    input cs_n, sclk, sync_n,
    output sdo, conversion_ready_strobe
  );
  modport host (
    output cs_n, sclk, sync_n,
    input sdo, conversion_ready_strobe
  );
endinterface
`default_nettype wire

// ==== verilog/ccr_device.sv ====
// Converter end: frames each result and shifts it out on sdo.
// Assumes link pins are asynchronous; sampled through two flops.
`default_nettype none
`include "ccr_map.svh"
// Overview of operation
// [RL1] Host holds chip select low while reading
// [RL2] No address bits; results stream directly
// [RL3] Strap mode defaults to continuous readback
// [RL4] Frame: 24-bit result plus eight trailing bits
// [RL5] Strap mode trailing byte is always status
// [RL6] Host serial clock divides its master clock
// [RL7] Host runs serial clock for whole period
// [RL8] Last bit held until next strobe rise
// [RL9] Host configures, enters readback, then syncs
// [RL10] Sync after strobe applies settings, resets filter
// [RL11] Host aligns frames to the ready strobe
// [RL12] Serial clock high at strobe rise
// [RL13] Data output reset on each strobe rise
// [RL14] MSB driven on first falling clock edge
// [RL15] Strap mode final frame bit always one
// [RL16] Shift MSB first, result then trailer
// [RL17] Ready indication only in continuous readback
// [RL18] Register mode may append status header
module ccr_device
  import ccr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  ccr_link_if.device link,
  input wire logic [`CCR_RESULT_BITS-1:0] result_data,
  input wire logic result_valid,
  output logic result_ready,
  input wire logic [`CCR_TRAIL_BITS-1:0] status_byte,
  input wire logic [`CCR_TRAIL_BITS-1:0] crc_byte,
  input wire logic strap_mode,
  input wire logic crc_select,
  input wire logic cont_readback_en,
  input wire logic new_settings_valid,
  output logic settings_applied,
  output logic filter_reset,
  output logic sync_seen
);
  // Two-entry result buffer
  logic [`CCR_RESULT_BITS-1:0] buf_mem_ff [`CCR_BUF_DEPTH];
  logic buf_wp_ff, nxt_buf_wp, buf_rp_ff, nxt_buf_rp;
  logic [1:0] buf_cnt_ff, nxt_buf_cnt;
  logic buf_push, buf_pop;
  // Synchronisers
  logic [1:0] sclk_sy_ff, cs_sy_ff, sync_sy_ff;
  logic sclk_d_ff, sync_d_ff;
  logic sclk_fall, sclk_rise, sync_rise;
  // Frame state
  ccr_frame_t shreg_ff, nxt_shreg;
  ccr_cnt_t cnt_ff, nxt_cnt;
  logic sdo_ff, nxt_sdo;
  logic strobe_ff, nxt_strobe;
  logic [`CCR_CNT_W-1:0] per_ff, nxt_per;
  logic stat_ff, nxt_stat;
  logic filt_ff, nxt_filt;
  logic sync_ff_o, nxt_sync_o;
  logic trail_en;

  function automatic ccr_frame_t build_frame(
    input logic [`CCR_RESULT_BITS-1:0] r,
    input logic [`CCR_TRAIL_BITS-1:0] st,
    input logic [`CCR_TRAIL_BITS-1:0] cr,
    input logic strap,
    input logic csel
  );
    ccr_trail_t t;
    t = (strap || !csel) ? st : cr; // see [RL4] see [RL5] see [RL18]
    if (strap) begin
      t[`CCR_STATUS_LAST_BIT] = 1'b1; // see [RL15]
    end
    build_frame = {r, t}; // see [RL16]
  endfunction

  assign buf_push = result_valid && (buf_cnt_ff != 2'h2);
  // Strap mode forces continuous readback
  assign trail_en = strap_mode || cont_readback_en; // see [RL3] see [RL17]
  // Frame starts on the rise after the last bit, while sclk is high
  assign buf_pop = trail_en && !cs_sy_ff[1] && (buf_cnt_ff != 2'h0) &&
    (per_ff == 6'h00) && sclk_rise;
  assign sclk_fall = sclk_d_ff && !sclk_sy_ff[1];
  assign sclk_rise = !sclk_d_ff && sclk_sy_ff[1];
  assign sync_rise = !sync_d_ff && sync_sy_ff[1];

  always_comb begin
    nxt_buf_wp = buf_wp_ff ^ buf_push;
    nxt_buf_rp = buf_rp_ff ^ buf_pop;
    nxt_buf_cnt = buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      buf_wp_ff <= 1'b0;
      buf_rp_ff <= 1'b0;
      buf_cnt_ff <= 2'h0;
      result_ready <= 1'b0;
    end else begin
      buf_wp_ff <= nxt_buf_wp;
      buf_rp_ff <= nxt_buf_rp;
      buf_cnt_ff <= nxt_buf_cnt;
      result_ready <= (nxt_buf_cnt != 2'h2);
      if (buf_push) begin
        buf_mem_ff[buf_wp_ff] <= result_data;
      end
    end
  end

  // Frame engine: strobe each 32 serial clocks; data shifts on falls
  always_comb begin
    nxt_shreg = shreg_ff;
    nxt_cnt = cnt_ff;
    nxt_sdo = sdo_ff;
    nxt_strobe = 1'b0;
    nxt_per = per_ff;
    if (cs_sy_ff[1] || !trail_en) begin
      nxt_per = 6'h00;
      nxt_cnt = `CCR_FRAME_LEN;
      nxt_sdo = 1'b0;
    end else if (buf_pop) begin
      nxt_strobe = 1'b1;
      nxt_sdo = 1'b0; // see [RL13]
      nxt_shreg = build_frame(buf_mem_ff[buf_rp_ff], status_byte,
        crc_byte, strap_mode, crc_select);
      nxt_cnt = 6'h00;
    end else if (sclk_fall) begin
      nxt_per = (per_ff == `CCR_FRAME_LAST) ? 6'h00 : per_ff + 6'h01;
      if (cnt_ff != `CCR_FRAME_LEN) begin
        nxt_sdo = shreg_ff[`CCR_FRAME_BITS-1]; // see [RL14] see [RL2]
        nxt_shreg = {shreg_ff[`CCR_FRAME_BITS-2:0], 1'b0};
        nxt_cnt = cnt_ff + 6'h01;
      end
      // Once count hits length the LSB stays put
    end // see [RL8]
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shreg_ff <= '0;
      cnt_ff <= `CCR_FRAME_LEN;
      sdo_ff <= 1'b0;
      strobe_ff <= 1'b0;
      per_ff <= 6'h00;
    end else begin
      shreg_ff <= nxt_shreg;
      cnt_ff <= nxt_cnt;
      sdo_ff <= nxt_sdo;
      strobe_ff <= nxt_strobe;
      per_ff <= nxt_per;
    end
  end

  // Sync pulse applies settings and flushes filter
  always_comb begin
    nxt_stat = new_settings_valid && sync_rise; // see [RL10]
    nxt_filt = sync_rise;
    nxt_sync_o = sync_rise;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sclk_sy_ff <= 2'h3;
      cs_sy_ff <= 2'h3;
      sync_sy_ff <= 2'h3;
      sclk_d_ff <= 1'b1;
      sync_d_ff <= 1'b1;
      stat_ff <= 1'b0;
      filt_ff <= 1'b0;
      sync_ff_o <= 1'b0;
    end else begin
      sclk_sy_ff <= {sclk_sy_ff[0], link.sclk};
      cs_sy_ff <= {cs_sy_ff[0], link.cs_n};
      sync_sy_ff <= {sync_sy_ff[0], !link.sync_n};
      sclk_d_ff <= sclk_sy_ff[1];
      sync_d_ff <= sync_sy_ff[1];
      stat_ff <= nxt_stat;
      filt_ff <= nxt_filt;
      sync_ff_o <= nxt_sync_o;
    end
  end

  assign link.sdo = sdo_ff;
  assign link.conversion_ready_strobe = strobe_ff;
  assign settings_applied = stat_ff;
  assign filter_reset = filt_ff;
  assign sync_seen = sync_ff_o;
endmodule // ccr_device
`default_nettype wire

// ==== verilog/ccr_host.sv ====
// Host end: makes the serial clock, captures frames on strobe.
// Assumes device pins are asynchronous; sampled through two flops.
`default_nettype none
`include "ccr_map.svh"
module ccr_host
  import ccr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  ccr_link_if.host link,
  input wire logic link_enable,
  input wire logic sync_req,
  output logic [`CCR_FRAME_BITS-1:0] frame_data,
  output logic frame_valid,
  input wire logic frame_ready,
  output logic busy
);
  ccr_state_t st_ff, nxt_st;
  logic [`CCR_SCLK_DIV_W-1:0] div_ff, nxt_div;
  logic sclk_ff, nxt_sclk;
  logic cs_ff, nxt_cs;
  logic sync_ff, nxt_sync;
  logic [1:0] sdo_sy_ff, stb_sy_ff;
  logic stb_d_ff;
  logic stb_rise, samp_now;
  logic busy_ff;
  ccr_frame_t sh_ff, nxt_sh;
  ccr_cnt_t cnt_ff, nxt_cnt;
  ccr_frame_t out_ff, nxt_out;
  logic val_ff, nxt_val;
  logic pend_ff, nxt_pend;

  assign stb_rise = stb_sy_ff[1] && !stb_d_ff;
  // Sample just before the fall: the round trip through both
  // synchronisers is longer than half a serial clock
  assign samp_now = (div_ff == `CCR_SCLK_HALF) && sclk_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_div = div_ff;
    nxt_sclk = sclk_ff;
    nxt_cs = cs_ff;
    nxt_sync = 1'b0;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    nxt_val = val_ff && !frame_ready;
    nxt_pend = pend_ff || sync_req;
    // Divided clock runs from selection on; device needs it to strobe
    if (st_ff != CCR_IDLE) begin
      nxt_div = (div_ff == `CCR_SCLK_HALF) ? '0 : div_ff + 4'h1;
      if (div_ff == `CCR_SCLK_HALF) begin
        nxt_sclk = !sclk_ff; // see [RL6] see [RL7] see [RL12]
      end
      // Leave only as a low phase ends, so it is never cut short
      if (!link_enable && div_ff == `CCR_SCLK_HALF && !sclk_ff) begin
        nxt_st = CCR_IDLE;
        nxt_cs = 1'b1;
      end
    end
    case (st_ff)
      CCR_IDLE: begin
        nxt_cs = 1'b1;
        nxt_sclk = 1'b1;
        nxt_div = '0;
        if (link_enable) begin
          nxt_st = CCR_WAIT;
          nxt_cs = 1'b0; // see [RL1]
        end
      end
      CCR_WAIT: begin
        // Align to first strobe, then shift in each frame
        if (stb_rise && link_enable) begin // see [RL11]
          nxt_st = CCR_SHIFT;
          nxt_cnt = '0;
        end
      end
      CCR_SHIFT: begin
        if (samp_now && cnt_ff != `CCR_FRAME_LEN) begin
          nxt_sh = {sh_ff[`CCR_FRAME_BITS-2:0], sdo_sy_ff[1]};
          nxt_cnt = cnt_ff + 6'h01;
        end
        if (stb_rise) begin
          if (cnt_ff == `CCR_FRAME_LEN && !val_ff) begin
            nxt_out = sh_ff;
            nxt_val = 1'b1;
          end
          nxt_cnt = '0;
          if (pend_ff) begin
            nxt_sync = 1'b1; // see [RL9] see [RL10]
            nxt_pend = sync_req;
          end
        end
      end
      default: nxt_st = CCR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_ff <= CCR_IDLE;
      div_ff <= '0;
      sclk_ff <= 1'b1;
      cs_ff <= 1'b1;
      sync_ff <= 1'b0;
      sh_ff <= '0;
      cnt_ff <= '0;
      out_ff <= '0;
      val_ff <= 1'b0;
      pend_ff <= 1'b0;
      sdo_sy_ff <= 2'h0;
      stb_sy_ff <= 2'h0;
      stb_d_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_st != CCR_IDLE);
      st_ff <= nxt_st;
      div_ff <= nxt_div;
      sclk_ff <= nxt_sclk;
      cs_ff <= nxt_cs;
      sync_ff <= nxt_sync;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
      val_ff <= nxt_val;
      pend_ff <= nxt_pend;
      sdo_sy_ff <= {sdo_sy_ff[0], link.sdo};
      stb_sy_ff <= {stb_sy_ff[0], link.conversion_ready_strobe};
      stb_d_ff <= stb_sy_ff[1];
    end
  end

  assign link.cs_n = cs_ff;
  assign link.sclk = sclk_ff;
  assign link.sync_n = !sync_ff;
  assign frame_data = out_ff;
  assign frame_valid = val_ff;
  assign busy = busy_ff;
endmodule // ccr_host
`default_nettype wire

// ==== test/ccr_props.sv ====
// Checker on the link pins between the two ends.
// Assumes one core_clk domain; inputs come from the interface.
`default_nettype none
module ccr_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic conversion_ready_strobe,
  input wire logic sync_n
);
  logic stb;
  logic [4:0] falls_ff;
  logic [4:0] nxt_falls;
  logic seen_ff;
  logic nxt_seen;
  logic sclk_ff;
  logic nxt_sclk;
  assign stb = conversion_ready_strobe;
  // Serial clock falls since the last strobe
  always_comb begin
    nxt_sclk = sclk;
    nxt_seen = ~cs_n & (seen_ff | stb);
    nxt_falls = stb ? 5'h00 : falls_ff + {4'h0, sclk_ff & ~sclk};
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      falls_ff <= 5'h00;
      seen_ff <= 1'b0;
      sclk_ff <= 1'b1;
    end else begin
      falls_ff <= nxt_falls;
      seen_ff <= nxt_seen;
      sclk_ff <= nxt_sclk;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_low4; !sclk [*4]; endsequence
  sequence s_high; !cs_n && !stb && sclk && $past(sclk); endsequence
  property p_cs_low; stb |-> !cs_n; endproperty
  property p_stb_one; stb |=> !stb; endproperty
  property p_sdo_clr; stb |-> !sdo; endproperty
  property p_half; $fell(sclk) |-> s_low4; endproperty
  property p_hold; s_high |-> $stable(sdo); endproperty
  property p_idle; cs_n [*6] |-> !sdo; endproperty
  property p_sync; $fell(sync_n) |=> sync_n; endproperty
  property p_len; stb && seen_ff |-> falls_ff == 5'h00; endproperty
  a_cs_low: assert property (p_cs_low)
    else $error("strobe while deselected");
  a_stb_one: assert property (p_stb_one)
    else $error("strobe too wide");
  a_sdo_clr: assert property (p_sdo_clr)
    else $error("data not cleared at strobe");
  a_half: assert property (p_half)
    else $error("serial clock low phase short");
  a_hold: assert property (p_hold)
    else $error("data moved while clock high");
  a_idle: assert property (p_idle)
    else $error("data driven while deselected");
  a_sync: assert property (p_sync)
    else $error("sync pulse too wide");
  a_len: assert property (p_len)
    else $error("frame not 32 clocks");
endmodule // ccr_props
`default_nettype wire

// ==== test/tb_continuous_conversion_readback_port.sv ====
// Bench: both ends joined over the link, driven from their user sides.
// Assumes design and checker files are compiled before it.
`default_nettype none
module tb_continuous_conversion_readback_port
  import ccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic strap;
    logic csel;
    ccr_result_t res;
    ccr_trail_t st;
    ccr_trail_t cr;
    ccr_frame_t exp;
  } ccr_row_t;
  ccr_row_t rows [4] = '{
    '{1'b1, 1'b0, 24'hA5A5A5, 8'h3C, 8'h77, 32'hA5A5A53D},
    '{1'b1, 1'b1, 24'hFFFFFF, 8'h80, 8'h11, 32'hFFFFFF81},
    '{1'b0, 1'b0, 24'h000000, 8'h5A, 8'hC3, 32'h0000005A},
    '{1'b0, 1'b1, 24'h800001, 8'h5A, 8'hC3, 32'h800001C3}
  };
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  ccr_result_t result_data = 24'h000000;
  logic result_valid = 1'b0;
  logic result_ready;
  ccr_trail_t status_byte = 8'h00;
  ccr_trail_t crc_byte = 8'h00;
  logic strap_mode = 1'b0;
  logic crc_select = 1'b0;
  logic cont_readback_en = 1'b1;
  logic new_settings_valid = 1'b0;
  logic settings_applied;
  logic filter_reset;
  logic sync_seen;
  logic link_enable = 1'b0;
  logic sync_req = 1'b0;
  ccr_frame_t frame_data;
  logic frame_valid;
  logic frame_ready = 1'b1;
  logic busy;
  int bad_count = 0;
  int n_compared = 0;
  int i;
  ccr_link_if link ();
  ccr_device ccr_device_inst (.core_clk, .reset_n, .link, .result_data,
    .result_valid, .result_ready, .status_byte, .crc_byte, .strap_mode,
    .crc_select, .cont_readback_en, .new_settings_valid,
    .settings_applied, .filter_reset, .sync_seen);
  ccr_host ccr_host_inst (.core_clk, .reset_n, .link, .link_enable,
    .sync_req, .frame_data, .frame_valid, .frame_ready, .busy);
  ccr_props ccr_props_inst (.core_clk, .reset_n, .cs_n(link.cs_n),
    .sclk(link.sclk), .sdo(link.sdo), .sync_n(link.sync_n),
    .conversion_ready_strobe(link.conversion_ready_strobe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hands one result over once the buffer has room
  task automatic push(input ccr_result_t d);
    for (i = 0; i < 2000 && result_ready !== 1'b1; i++) @(negedge core_clk);
    result_data = d;
    result_valid = 1'b1;
    @(negedge core_clk);
    result_valid = 1'b0;
  endtask
  task automatic take(input ccr_frame_t exp);
    for (i = 0; i < 3000 && frame_valid !== 1'b1; i++) @(negedge core_clk);
    check(frame_data, exp);
  endtask
  // Drops the link; the host leaves as a low phase ends
  task automatic stop_link();
    for (i = 0; i < 20 && link.sclk !== 1'b1; i++) @(negedge core_clk);
    link_enable = 1'b0;
    repeat (40) @(negedge core_clk);
  endtask
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #300000;
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (3) @(negedge core_clk);
    check(32'({link.cs_n, link.sclk, link.sdo, link.conversion_ready_strobe,
      link.sync_n, frame_valid, result_ready}), 32'h64);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check(32'(result_ready), 32'h1);
    $display("reset test done");
    foreach (rows[k]) begin
      strap_mode = rows[k].strap;
      crc_select = rows[k].csel;
      status_byte = rows[k].st;
      crc_byte = rows[k].cr;
      push(rows[k].res);
      push(rows[k].res);
      @(negedge core_clk);
      check(32'(result_ready), 32'h0);
      link_enable = 1'b1;
      take(rows[k].exp);
      check(32'(busy), 32'h1);
      stop_link();
      check(32'(busy), 32'h0);
      $display("row %0d done", k);
    end
    // Receiver stalls; a later frame must not replace the held one
    strap_mode = 1'b0;
    crc_select = 1'b0;
    status_byte = 8'h01;
    frame_ready = 1'b0;
    push(24'h123456);
    push(24'h654321);
    link_enable = 1'b1;
    take(32'h12345601);
    push(24'h0F0F0F);
    repeat (600) @(negedge core_clk);
    check(frame_data, 32'h12345601);
    check(32'(frame_valid), 32'h1);
    frame_ready = 1'b1;
    $display("stall test done");
    push(24'h000001);
    new_settings_valid = 1'b1;
    sync_req = 1'b1;
    @(negedge core_clk);
    sync_req = 1'b0;
    for (i = 0; i < 2000 && settings_applied !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    check(32'({settings_applied, filter_reset}), 32'h3);
    $display("sync test done");
    end_sim();
  end
endmodule // tb_continuous_conversion_readback_port
`default_nettype wire
